/* File: dmsr_top.sv */
// read-only monitor register bank of a motor drive
// Functional notes
// - every monitor word is read-only; writes change nothing and are refused
// - status bit 0 shows running, bit 1 shows reverse rotation
// - status bit 2 startup done, bit 3 fault present, bit 4 setting error
// - status bits 5 and 6 mirror digital outputs 1 and 2
// - fault bits 0..3: overcurrent/ground, overvoltage, drive overload, overheat; bit 4 zero
// - fault bit 5 fuse blown, bit 6 PI feedback loss, bit 7 external error
// - fault bit 8 hardware error, bit 9 motor overload or overtorque
// - fault bit 10 encoder wire break, overspeed or speed deviation
// - fault bit 11 undervoltage alarm, bit 12 undervoltage trip or supply faults
// - fault bit 13 phase loss, bit 14 comm error, bit 15 keypad detached
// - link bit 0 writing, bit 3 limit error, bit 4 integrity error
`timescale 1ns/1ps
module dmsr_top (
   // clock and control
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // register access from the link controller
   input  wire logic        rd_req,
   input  wire logic        wr_req,
   input  wire logic [15:0] reg_addr,
   output logic      [15:0] rd_data,
   output logic             rd_valid,
   output logic             acc_err,
   // drive state levels, asynchronous
   input  wire logic        motor_running,
   input  wire logic        motor_reverse,
   input  wire logic        startup_done,
   input  wire logic        fault_active,
   input  wire logic        data_set_error,
   input  wire logic        dout1_on,
   input  wire logic        dout2_on,
   // trip sources, asynchronous
   input  wire logic        current_excess_trip,
   input  wire logic        ground_leak_trip,
   input  wire logic        dc_bus_high_voltage_trip,
   input  wire logic        drive_overload_trip,
   input  wire logic        drive_heat_trip_a,
   input  wire logic        drive_heat_trip_b,
   input  wire logic        fuse_blown_trip,
   input  wire logic        pi_feedback_loss,
   input  wire logic        external_trip,
   input  wire logic        comm_external_trip,
   input  wire logic        hardware_trip,
   input  wire logic        motor_overload_trip,
   input  wire logic        torque_excess_trip,
   input  wire logic        encoder_wire_break,
   input  wire logic        speed_excess_trip,
   input  wire logic        speed_mismatch_trip,
   input  wire logic        bus_low_voltage_alarm,
   input  wire logic        bus_low_voltage_trip,
   input  wire logic        control_supply_trip,
   input  wire logic        inrush_circuit_trip,
   input  wire logic        power_loss_trip,
   input  wire logic        output_phase_loss,
   input  wire logic        modbus_comm_error,
   input  wire logic        keypad_detached,
   // link write state, same clock
   input  wire logic        link_writing,
   input  wire logic        link_limit_error,
   input  wire logic        link_integrity_error,
   // panel monitor values, same clock
   input  wire logic [15:0] freq_ref_monitor,
   input  wire logic [15:0] output_freq_monitor,
   input  wire logic [15:0] output_voltage_monitor,
   input  wire logic [15:0] output_current_monitor,
   input  wire logic [15:0] output_power_monitor,
   input  wire logic [15:0] torque_ref_monitor
);
   localparam int NPIN = 31;

   typedef struct packed {
      logic [15:0] rd_data;
      logic        rd_valid;
      logic        acc_err;
   } dmsr_top_t;

   dmsr_top_t   st_r;
   dmsr_top_t   st_nxt;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   logic [15:0] run_word;
   logic [15:0] trip_word;
   logic [15:0] link_word;
   logic [15:0] mux_data;
   logic        mux_hit;

   // pins cross into the clock domain before anyone reads them
   assign pin_raw = {motor_running, motor_reverse, startup_done, fault_active,
                     data_set_error, dout1_on, dout2_on,
                     current_excess_trip, ground_leak_trip, dc_bus_high_voltage_trip,
                     drive_overload_trip, drive_heat_trip_a, drive_heat_trip_b,
                     fuse_blown_trip, pi_feedback_loss, external_trip, comm_external_trip,
                     hardware_trip, motor_overload_trip, torque_excess_trip,
                     encoder_wire_break, speed_excess_trip, speed_mismatch_trip,
                     bus_low_voltage_alarm, bus_low_voltage_trip, control_supply_trip,
                     inrush_circuit_trip, power_loss_trip, output_phase_loss,
                     modbus_comm_error, keypad_detached};

   dmsr_sync #(.W(NPIN)) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   (pin_raw),
      .q   (pin_s)
   );

   // synced indices follow the concatenation order above
   always_comb begin
      run_word = dmsr_pkg::ZERO_WORD;
      run_word[dmsr_pkg::RS_RUN]    = pin_s[30];
      run_word[dmsr_pkg::RS_REV]    = pin_s[29];
      run_word[dmsr_pkg::RS_READY]  = pin_s[28];
      run_word[dmsr_pkg::RS_FAULT]  = pin_s[27];
      run_word[dmsr_pkg::RS_SETERR] = pin_s[26];
      run_word[dmsr_pkg::RS_DOUT1]  = pin_s[25];
      run_word[dmsr_pkg::RS_DOUT2]  = pin_s[24];
   end

   always_comb begin
      trip_word = dmsr_pkg::ZERO_WORD;
      trip_word[dmsr_pkg::TC_CURR]    = pin_s[23] | pin_s[22];
      trip_word[dmsr_pkg::TC_OVOLT]   = pin_s[21];
      trip_word[dmsr_pkg::TC_DRV_OL]  = pin_s[20];
      trip_word[dmsr_pkg::TC_HEAT]    = pin_s[19] | pin_s[18];
      trip_word[dmsr_pkg::TC_FUSE]    = pin_s[17];
      trip_word[dmsr_pkg::TC_PIFB]    = pin_s[16];
      trip_word[dmsr_pkg::TC_EXT]     = pin_s[15] | pin_s[14];
      trip_word[dmsr_pkg::TC_HW]      = pin_s[13];
      trip_word[dmsr_pkg::TC_MOT_OL]  = pin_s[12] | pin_s[11];
      trip_word[dmsr_pkg::TC_SPEED]   = pin_s[10] | pin_s[9] | pin_s[8];
      trip_word[dmsr_pkg::TC_UV_ALM]  = pin_s[7];
      trip_word[dmsr_pkg::TC_UV_TRIP] = pin_s[6] | pin_s[5] | pin_s[4] | pin_s[3];
      trip_word[dmsr_pkg::TC_PHASE]   = pin_s[2];
      trip_word[dmsr_pkg::TC_COMM]    = pin_s[1];
      trip_word[dmsr_pkg::TC_KEYPAD]  = pin_s[0];
   end

   always_comb begin
      link_word = dmsr_pkg::ZERO_WORD;
      link_word[dmsr_pkg::LS_WRITING] = link_writing;
      link_word[dmsr_pkg::LS_LIMIT]   = link_limit_error;
      link_word[dmsr_pkg::LS_INTEG]   = link_integrity_error;
   end

   dmsr_word_mux u_mux (
      .addr       (reg_addr),
      .run_state  (run_word),
      .trip_cause (trip_word),
      .link_state (link_word),
      .freq_ref   (freq_ref_monitor),
      .out_freq   (output_freq_monitor),
      .out_volt   (output_voltage_monitor),
      .out_curr   (output_current_monitor),
      .out_power  (output_power_monitor),
      .torque_ref (torque_ref_monitor),
      .data       (mux_data),
      .hit        (mux_hit)
   );

   // one answer a cycle after each request taken while ce is high; with ce low the answer holds; a write only earns an error
   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         st_nxt.rd_valid = 1'b0;
         st_nxt.acc_err  = 1'b0;
         if (wr_req) begin
            st_nxt.acc_err = 1'b1;
            st_nxt.rd_data = dmsr_pkg::ZERO_WORD;
         end else if (rd_req) begin
            st_nxt.rd_valid = mux_hit;
            st_nxt.acc_err  = ~mux_hit;
            st_nxt.rd_data  = mux_hit ? mux_data : dmsr_pkg::ZERO_WORD;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data  = st_r.rd_data;
   assign rd_valid = st_r.rd_valid;
   assign acc_err  = st_r.acc_err;

   // checks
   sequence s_rd_hit;
      ce && rd_req && !wr_req && mux_hit;
   endsequence

   AST_WR_REFUSED: assert property (@(posedge clk) disable iff (rst)
      ce && wr_req |=> acc_err && !rd_valid && rd_data == dmsr_pkg::ZERO_WORD)
      else $error("write not refused");
   AST_RUN_BIT: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_RUN_STATE
      |=> rd_data[dmsr_pkg::RS_RUN] == $past(pin_s[30]))
      else $error("run bit wrong");
   AST_FAULT_BIT: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_RUN_STATE
      |=> rd_data[dmsr_pkg::RS_FAULT] == $past(pin_s[27]))
      else $error("fault bit wrong");
   AST_DOUT_BITS: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_RUN_STATE
      |=> rd_data[6:5] == {$past(pin_s[24]), $past(pin_s[25])} && rd_data[15:7] == 9'h000)
      else $error("output mirror wrong");
   AST_CURR_BIT: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_TRIP_CAUSE
      |=> rd_data[dmsr_pkg::TC_CURR] == ($past(pin_s[23]) | $past(pin_s[22])) && !rd_data[4])
      else $error("overcurrent bit wrong");
   AST_EXT_BIT: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_TRIP_CAUSE
      |=> rd_data[dmsr_pkg::TC_EXT] == ($past(pin_s[15]) | $past(pin_s[14])))
      else $error("external bit wrong");
   AST_KEYPAD_BIT: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_TRIP_CAUSE
      |=> rd_data[dmsr_pkg::TC_KEYPAD] == $past(pin_s[0]))
      else $error("keypad bit wrong");
   AST_LINK_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_LINK_STATE
      |=> rd_data == {11'h000, $past(link_integrity_error), $past(link_limit_error), 2'h0, $past(link_writing)})
      else $error("link word wrong");
   AST_FREQ_WORD: assert property (@(posedge clk) disable iff (rst)
      s_rd_hit and (reg_addr == dmsr_pkg::REG_FREQ_REF)
      |=> rd_valid && rd_data == $past(freq_ref_monitor))
      else $error("frequency word wrong");
   AST_SPARE_ZERO: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && (reg_addr == dmsr_pkg::REG_SPARE_A || reg_addr == dmsr_pkg::REG_SPARE_B)
      |=> rd_valid && rd_data == dmsr_pkg::ZERO_WORD)
      else $error("spare word not zero");

   sequence s_rd_run;
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_RUN_STATE;
   endsequence
   sequence s_rd_trip;
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_TRIP_CAUSE;
   endsequence
   sequence s_rd_miss;
      ce && rd_req && !wr_req && !mux_hit;
   endsequence

   // status bits follow the synchronised pins, one cycle behind the request
   AST_REV_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_run
      |=> rd_data[dmsr_pkg::RS_REV] == $past(pin_s[29]))
      else $error("reverse bit wrong");
   AST_READY_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_run
      |=> rd_data[dmsr_pkg::RS_READY] == $past(pin_s[28]))
      else $error("startup bit wrong");
   AST_SETERR_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_run
      |=> rd_data[dmsr_pkg::RS_SETERR] == $past(pin_s[26]))
      else $error("setting error bit wrong");

   // fault bits are live levels, not sticky
   AST_OVOLT_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_OVOLT] == $past(pin_s[21]))
      else $error("overvoltage bit wrong");
   AST_DRV_OL_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_DRV_OL] == $past(pin_s[20]))
      else $error("drive overload bit wrong");
   AST_HEAT_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_HEAT] == ($past(pin_s[19]) | $past(pin_s[18])))
      else $error("overheat bit wrong");
   AST_FUSE_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_FUSE] == $past(pin_s[17]))
      else $error("fuse bit wrong");
   AST_PIFB_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_PIFB] == $past(pin_s[16]))
      else $error("feedback loss bit wrong");
   AST_HW_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_HW] == $past(pin_s[13]))
      else $error("hardware bit wrong");
   AST_MOT_OL_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_MOT_OL] == ($past(pin_s[12]) | $past(pin_s[11])))
      else $error("motor overload bit wrong");
   AST_SPEED_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_SPEED] == ($past(pin_s[10]) | $past(pin_s[9]) | $past(pin_s[8])))
      else $error("speed bit wrong");
   AST_UV_ALM_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_UV_ALM] == $past(pin_s[7]))
      else $error("undervoltage alarm bit wrong");
   AST_UV_TRIP_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_UV_TRIP] == ($past(pin_s[6]) | $past(pin_s[5]) | $past(pin_s[4]) | $past(pin_s[3])))
      else $error("undervoltage trip bit wrong");
   AST_PHASE_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_PHASE] == $past(pin_s[2]))
      else $error("phase loss bit wrong");
   AST_COMM_BIT: assert property (@(posedge clk) disable iff (rst)
      s_rd_trip
      |=> rd_data[dmsr_pkg::TC_COMM] == $past(pin_s[1]))
      else $error("comm error bit wrong");

   // panel words are same-clock values and pass without a synchroniser
   AST_OUT_FREQ_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_OUT_FREQ
      |=> rd_valid && rd_data == $past(output_freq_monitor))
      else $error("output frequency word wrong");
   AST_OUT_VOLT_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_OUT_VOLT
      |=> rd_valid && rd_data == $past(output_voltage_monitor))
      else $error("output voltage word wrong");
   AST_OUT_CURR_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_OUT_CURR
      |=> rd_valid && rd_data == $past(output_current_monitor))
      else $error("output current word wrong");
   AST_OUT_POWER_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_OUT_POWER
      |=> rd_valid && rd_data == $past(output_power_monitor))
      else $error("output power word wrong");
   AST_TORQUE_WORD: assert property (@(posedge clk) disable iff (rst)
      ce && rd_req && !wr_req && reg_addr == dmsr_pkg::REG_TORQUE_REF
      |=> rd_valid && rd_data == $past(torque_ref_monitor))
      else $error("torque word wrong");

   // a mapped read answers valid; an unmapped one earns an error and a zero word
   AST_RD_ANSWERED: assert property (@(posedge clk) disable iff (rst)
      s_rd_hit
      |=> rd_valid && !acc_err)
      else $error("mapped read not answered");
   AST_MISS_REFUSED: assert property (@(posedge clk) disable iff (rst)
      s_rd_miss
      |=> acc_err && !rd_valid && rd_data == dmsr_pkg::ZERO_WORD)
      else $error("unmapped read not refused");
endmodule

/* File: dmsr_pkg.sv */
// constants for the drive monitor status register bank
package dmsr_pkg;
   localparam int DW = 16;
   localparam int AW = 16;
   // register numbers
   localparam logic [15:0] REG_RUN_STATE   = 16'h0020;
   localparam logic [15:0] REG_TRIP_CAUSE  = 16'h0021;
   localparam logic [15:0] REG_LINK_STATE  = 16'h0022;
   localparam logic [15:0] REG_FREQ_REF    = 16'h0023;
   localparam logic [15:0] REG_OUT_FREQ    = 16'h0024;
   localparam logic [15:0] REG_OUT_VOLT    = 16'h0025;
   localparam logic [15:0] REG_OUT_CURR    = 16'h0026;
   localparam logic [15:0] REG_OUT_POWER   = 16'h0027;
   localparam logic [15:0] REG_TORQUE_REF  = 16'h0028;
   localparam logic [15:0] REG_SPARE_A     = 16'h0029;
   localparam logic [15:0] REG_SPARE_B     = 16'h002a;
   // run state bits
   localparam int RS_RUN      = 0;
   localparam int RS_REV      = 1;
   localparam int RS_READY    = 2;
   localparam int RS_FAULT    = 3;
   localparam int RS_SETERR   = 4;
   localparam int RS_DOUT1    = 5;
   localparam int RS_DOUT2    = 6;
   // trip cause bits
   localparam int TC_CURR     = 0;
   localparam int TC_OVOLT    = 1;
   localparam int TC_DRV_OL   = 2;
   localparam int TC_HEAT     = 3;
   localparam int TC_FUSE     = 5;
   localparam int TC_PIFB     = 6;
   localparam int TC_EXT      = 7;
   localparam int TC_HW       = 8;
   localparam int TC_MOT_OL   = 9;
   localparam int TC_SPEED    = 10;
   localparam int TC_UV_ALM   = 11;
   localparam int TC_UV_TRIP  = 12;
   localparam int TC_PHASE    = 13;
   localparam int TC_COMM     = 14;
   localparam int TC_KEYPAD   = 15;
   // link state bits
   localparam int LS_WRITING  = 0;
   localparam int LS_LIMIT    = 3;
   localparam int LS_INTEG    = 4;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage

/* File: dmsr_sync.sv */
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module dmsr_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dmsr_sync_t;
   dmsr_sync_t st_r;
   dmsr_sync_t st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         st_nxt.s1 = d;
         st_nxt.s2 = st_r.s1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.s2;
endmodule

/* File: dmsr_word_mux.sv */
// read data selector for the monitor words
`timescale 1ns/1ps
module dmsr_word_mux (
   // request
   input  wire logic [15:0] addr,
   // word sources
   input  wire logic [15:0] run_state,
   input  wire logic [15:0] trip_cause,
   input  wire logic [15:0] link_state,
   input  wire logic [15:0] freq_ref,
   input  wire logic [15:0] out_freq,
   input  wire logic [15:0] out_volt,
   input  wire logic [15:0] out_curr,
   input  wire logic [15:0] out_power,
   input  wire logic [15:0] torque_ref,
   // result
   output logic      [15:0] data,
   output logic             hit
);
   always_comb begin
      data = dmsr_pkg::ZERO_WORD;
      hit  = 1'b1;
      unique case (addr)
         dmsr_pkg::REG_RUN_STATE:  data = run_state;
         dmsr_pkg::REG_TRIP_CAUSE: data = trip_cause;
         dmsr_pkg::REG_LINK_STATE: data = link_state;
         dmsr_pkg::REG_FREQ_REF:   data = freq_ref;
         dmsr_pkg::REG_OUT_FREQ:   data = out_freq;
         dmsr_pkg::REG_OUT_VOLT:   data = out_volt;
         dmsr_pkg::REG_OUT_CURR:   data = out_curr;
         dmsr_pkg::REG_OUT_POWER:  data = out_power;
         dmsr_pkg::REG_TORQUE_REF: data = torque_ref;
         dmsr_pkg::REG_SPARE_A:    data = dmsr_pkg::ZERO_WORD;
         dmsr_pkg::REG_SPARE_B:    data = dmsr_pkg::ZERO_WORD;
         default:                  hit  = 1'b0;
      endcase
   end
endmodule

/* File: dmsr_link_master.sv */
// link master model that requests monitor words from the register bank
`timescale 1ns/1ps
module dmsr_link_master (
   // clock
   input  wire logic        clk,
   // request side
   output logic             rd_req,
   output logic             wr_req,
   output logic      [15:0] reg_addr,
   // answer side
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   input  wire logic        acc_err
);
   initial begin
      rd_req   = 1'b0;
      wr_req   = 1'b0;
      reg_addr = 16'h0000;
   end

   // called just after an edge; the request is taken at the next edge and the answer sampled right after it
   task automatic access(input logic wr, input logic [15:0] a, input logic hold,
                         output logic v, output logic e, output logic [15:0] d);
      rd_req   = !wr;
      wr_req   = wr;
      reg_addr = a;
      @(posedge clk);
      #1;
      v = rd_valid;
      e = acc_err;
      d = rd_data;
      // released address shows the inverse so a stale value is never read as valid
      if (!hold) begin
         rd_req   = 1'b0;
         wr_req   = 1'b0;
         reg_addr = ~a;
         // one idle edge, so a following call never flips a strobe within the same step
         @(posedge clk);
         #1;
      end
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the drive monitor register bank
`timescale 1ns/1ps
module testbench;
   logic        clk;
   logic        rst;
   logic        ce;
   logic        rd_req;
   logic        wr_req;
   logic [15:0] reg_addr;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic        acc_err;
   logic [6:0]  st;
   logic [23:0] tr;
   logic [2:0]  lk;
   logic [15:0] mon [0:5];
   logic        v;
   logic        e;
   logic [15:0] d;
   int          failures;
   int          n_checks;
   int          cyc;
   int          tmap [0:23] = '{0, 0, 1, 2, 3, 3, 5, 6, 7, 7, 8, 9, 9, 10, 10, 10, 11, 12, 12, 12, 12, 13, 14, 15};
   int          lmap [0:2] = '{0, 3, 4};

   dmsr_top dut_u (
      .clk(clk), .rst(rst), .ce(ce), .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .acc_err(acc_err),
      .motor_running(st[0]), .motor_reverse(st[1]), .startup_done(st[2]), .fault_active(st[3]),
      .data_set_error(st[4]), .dout1_on(st[5]), .dout2_on(st[6]),
      .current_excess_trip(tr[0]), .ground_leak_trip(tr[1]), .dc_bus_high_voltage_trip(tr[2]),
      .drive_overload_trip(tr[3]), .drive_heat_trip_a(tr[4]), .drive_heat_trip_b(tr[5]),
      .fuse_blown_trip(tr[6]), .pi_feedback_loss(tr[7]), .external_trip(tr[8]), .comm_external_trip(tr[9]),
      .hardware_trip(tr[10]), .motor_overload_trip(tr[11]), .torque_excess_trip(tr[12]),
      .encoder_wire_break(tr[13]), .speed_excess_trip(tr[14]), .speed_mismatch_trip(tr[15]),
      .bus_low_voltage_alarm(tr[16]), .bus_low_voltage_trip(tr[17]), .control_supply_trip(tr[18]),
      .inrush_circuit_trip(tr[19]), .power_loss_trip(tr[20]), .output_phase_loss(tr[21]),
      .modbus_comm_error(tr[22]), .keypad_detached(tr[23]),
      .link_writing(lk[0]), .link_limit_error(lk[1]), .link_integrity_error(lk[2]),
      .freq_ref_monitor(mon[0]), .output_freq_monitor(mon[1]), .output_voltage_monitor(mon[2]),
      .output_current_monitor(mon[3]), .output_power_monitor(mon[4]), .torque_ref_monitor(mon[5])
   );

   dmsr_link_master master_u (
      .clk(clk), .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .acc_err(acc_err)
   );

   always #2 clk = ~clk;

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // async pins need two synchroniser edges, so three is a safe settle
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err_exp, input logic hold);
      master_u.access(1'b0, a, hold, v, e, d);
      chk1(v, !err_exp, "valid");
      chk1(e, err_exp, "error");
      chk16(d, exp, "data");
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce  = 1'b1;
      st  = 7'h00;
      tr  = 24'h000000;
      lk  = 3'h0;
      for (int i = 0; i < 6; i++) begin
         mon[i] = 16'h1111 * 16'(i + 1);
      end
      settle(6);
      rst = 1'b0;
      rd(16'h0020, 16'h0000, 1'b0, 1'b0);
      for (int i = 0; i < 7; i++) begin
         st = 7'h01 << i;
         settle(3);
         rd(16'h0020, 16'h0001 << i, 1'b0, 1'b0);
      end
      st = 7'h00;
      for (int i = 0; i < 24; i++) begin
         tr = 24'h000001 << i;
         settle(3);
         rd(16'h0021, 16'h0001 << tmap[i], 1'b0, 1'b0);
      end
      tr = 24'hffffff;
      settle(3);
      rd(16'h0021, 16'hffef, 1'b0, 1'b0);
      tr = 24'h000000;
      for (int i = 0; i < 3; i++) begin
         lk = 3'h1 << i;
         settle(3);
         rd(16'h0022, 16'h0001 << lmap[i], 1'b0, 1'b0);
      end
      lk = 3'h7;
      settle(3);
      rd(16'h0022, 16'h0019, 1'b0, 1'b0);
      // back to back over all six values, request held high between them
      for (int i = 0; i < 6; i++) begin
         rd(16'h0023 + 16'(i), mon[i], 1'b0, i < 5);
      end
      rd(16'h0029, 16'h0000, 1'b0, 1'b0);
      rd(16'h002a, 16'h0000, 1'b0, 1'b0);
      rd(16'h002b, 16'h0000, 1'b1, 1'b0);
      rd(16'h001f, 16'h0000, 1'b1, 1'b0);
      st = 7'h7f;
      settle(3);
      for (int i = 0; i < 11; i++) begin
         master_u.access(1'b1, 16'h0020 + 16'(i), 1'b0, v, e, d);
         chk1(e, 1'b1, "write refused");
         chk1(v, 1'b0, "write valid");
         chk16(d, 16'h0000, "write data");
      end
      rd(16'h0020, 16'h007f, 1'b0, 1'b0);
      rd(16'h0023, mon[0], 1'b0, 1'b0);
      // clock enable low freezes the answer path
      ce = 1'b0;
      master_u.access(1'b1, 16'h0020, 1'b0, v, e, d);
      chk1(e, 1'b0, "frozen error");
      chk16(d, mon[0], "frozen data");
      ce = 1'b1;
      // reset in mid-run clears the read data
      rst = 1'b1;
      settle(2);
      rst = 1'b0;
      chk16(rd_data, 16'h0000, "data after reset");
      chk1(rd_valid, 1'b0, "valid after reset");
      chk1(acc_err, 1'b0, "error after reset");
      settle(3);
      rd(16'h0020, 16'h007f, 1'b0, 1'b0);
      tally_and_finish();
   end
endmodule
